// file: include/ssds_defs.vh
// Constants and timing counts of the sixfold switch diagnostic shifter
// Functional notes
// - Each of six channels turns on from its own high control input.
// - An enabled channel is watched for overload, which is flagged.
// - A disabled channel reports open load and short to ground separately.
// - A shorted load turns its output off about 10 us after onset.
// - Short shutdown is held per channel until its control input rises again.
// - A latched channel restarts only after its input goes low then high.
// - Overload, open load and short to ground of every channel set their own flags; a shorted load sets none.
// - Over 170 C sets the thermal flag; no output is turned off.
// - Word bit 1 is thermal; bits 2 to 4 are channel 6 flags.
// - Channels 5 down to 1 follow in three-flag groups, bits 5 to 19.
// - Flags stay stored until read out over the serial link.
// - The first serial clock pulse of a transfer clears the flags.
// - A low diagnostic reset input clears the error flags.
// - Diagnostic bits leave on the serial data output.
// - Serial input bits pass through so cascaded words reach the host.
// - The auxiliary switch follows its input only, with no flag.
`ifndef SSDS_DEFS_VH
`define SSDS_DEFS_VH

// Word geometry
`define SSDS_CHANNELS 6
`define SSDS_WORD_BITS 19
`define SSDS_FLAGS_RESET 19'h0_0000

// Flag order inside a channel group, counted from the group start
`define SSDS_GRP_OVERLOAD 0
`define SSDS_GRP_OPEN 1
`define SSDS_GRP_SHORT 2

// Short shutdown delay, in ns and in 50 ns clock cycles
`define SSDS_CLK_PERIOD_NS 50
`define SSDS_SHORT_DELAY_NS 10000
`define SSDS_SHORT_DELAY_CYC (`SSDS_SHORT_DELAY_NS / `SSDS_CLK_PERIOD_NS)

`endif

// file: design/ssds_sync2.v
// Two-flop synchroniser bank for inputs from outside the clock domain
`default_nettype none

module ssds_sync2 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// file: design/ssds_switch_diag.v
// Control, protection and serial diagnostic logic of the sixfold switch
`include "ssds_defs.vh"
`default_nettype none

module ssds_switch_diag #(
  parameter NCH = `SSDS_CHANNELS,
  parameter WBITS = `SSDS_WORD_BITS,
  parameter SHORT_CYC = `SSDS_SHORT_DELAY_CYC
) (
  input wire clk,
  input wire rst,
  input wire ctrl_in_ch1,
  input wire ctrl_in_ch2,
  input wire ctrl_in_ch3,
  input wire ctrl_in_ch4,
  input wire ctrl_in_ch5,
  input wire ctrl_in_ch6,
  input wire ctrl_in_aux,
  input wire [5:0] sense_overload,
  input wire [5:0] sense_open_load,
  input wire [5:0] sense_short_gnd,
  input wire [5:0] sense_shorted_load,
  input wire sense_overtemp,
  input wire diag_reset_n,
  input wire diag_cs_n,
  input wire diag_sclk,
  input wire diag_serial_in,
  output reg drain_ch1,
  output reg drain_ch2,
  output reg drain_ch3,
  output reg drain_ch4,
  output reg drain_ch5,
  output reg drain_ch6,
  output reg drain_aux,
  output reg diag_serial_out,
  output wire [WBITS-1:0] fault_flags
);

  // Synchronised pin inputs, packed as one bank
  localparam NSYNC = 7 + 4 * 6 + 5;
  wire [NSYNC-1:0] sync_bank;
  wire [5:0] ctrl_s;
  wire aux_s;
  wire [5:0] ovl_s;
  wire [5:0] open_s;
  wire [5:0] sgnd_s;
  wire [5:0] sld_s;
  wire otemp_s;
  wire dres_n_s;
  wire cs_n_s;
  wire sclk_s;
  wire sin_s;

  ssds_sync2 #(
    .WIDTH(NSYNC)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({ctrl_in_aux, ctrl_in_ch6, ctrl_in_ch5, ctrl_in_ch4,
               ctrl_in_ch3, ctrl_in_ch2, ctrl_in_ch1, sense_overload,
               sense_open_load, sense_short_gnd, sense_shorted_load,
               sense_overtemp, ~diag_reset_n, ~diag_cs_n, diag_sclk,
               diag_serial_in}),
    .sync_out(sync_bank)
  );

  assign aux_s = sync_bank[35];
  assign ctrl_s = sync_bank[34:29];
  assign ovl_s = sync_bank[28:23];
  assign open_s = sync_bank[22:17];
  assign sgnd_s = sync_bank[16:11];
  assign sld_s = sync_bank[10:5];
  assign otemp_s = sync_bank[4];
  // Active-low pins pass inverted so the bank's zero reset reads as
  // idle; otherwise a false select edge and clear would follow reset
  assign dres_n_s = ~sync_bank[3];
  assign cs_n_s = ~sync_bank[2];
  assign sclk_s = sync_bank[1];
  assign sin_s = sync_bank[0];

  // ----------------------------------------------------------------
  // Word position of a channel group; channel 6 sits right after
  // the thermal bit, channel 1 at the far end
  // ----------------------------------------------------------------
  function integer grp_base;
    input integer ch;
    begin
      grp_base = 1 + 3 * (NCH - 1 - ch);
    end
  endfunction

  // Edge history of the synchronised serial and control levels
  reg sclk_d_reg;
  reg cs_n_d_reg;
  reg [5:0] ctrl_d_reg;
  wire sclk_rise;
  wire cs_fall;
  wire [5:0] ctrl_rise;

  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign cs_fall = ~cs_n_s & cs_n_d_reg;
  assign ctrl_rise = ctrl_s & ~ctrl_d_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
      ctrl_d_reg <= 6'h0_0;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
      ctrl_d_reg <= ctrl_s;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel short timer and shutdown latch
  // ----------------------------------------------------------------
  localparam CW = 16;
  reg [5:0] latch_reg;
  reg [5:0] drv;
  genvar g;

  generate
    for (g = 0; g < 6; g = g + 1) begin : g_ch
      reg [CW-1:0] tmr_reg;
      wire on_req;
      wire expire;
      assign on_req = ctrl_s[g] & ~latch_reg[g];
      assign expire = (tmr_reg == SHORT_CYC[CW-1:0] - 16'h0001);

      // Short must persist for the full delay before shutdown
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          tmr_reg <= 16'h0000;
        end else if (on_req && sld_s[g] && !expire) begin
          tmr_reg <= tmr_reg + 16'h0001;
        end else if (!(on_req && sld_s[g])) begin
          tmr_reg <= 16'h0000;
        end
      end

      // Latch holds the channel off until a fresh rising input
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          latch_reg[g] <= 1'b0;
        end else if (on_req && sld_s[g] && expire) begin
          latch_reg[g] <= 1'b1;
        end else if (ctrl_rise[g]) begin
          latch_reg[g] <= 1'b0;
        end
      end

      always @* begin
        drv[g] = on_req;
      end
    end
  endgenerate

  // Outputs registered; the aux switch bypasses all protection
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      drain_ch1 <= 1'b0;
      drain_ch2 <= 1'b0;
      drain_ch3 <= 1'b0;
      drain_ch4 <= 1'b0;
      drain_ch5 <= 1'b0;
      drain_ch6 <= 1'b0;
      drain_aux <= 1'b0;
    end else begin
      drain_ch1 <= drv[0];
      drain_ch2 <= drv[1];
      drain_ch3 <= drv[2];
      drain_ch4 <= drv[3];
      drain_ch5 <= drv[4];
      drain_ch6 <= drv[5];
      drain_aux <= aux_s;
    end
  end

  // ----------------------------------------------------------------
  // Fault detection per word bit; index 0 is word bit 1
  // ----------------------------------------------------------------
  reg [WBITS-1:0] flag_set;
  integer i;

  always @* begin
    flag_set = {WBITS{1'b0}};
    flag_set[0] = otemp_s;
    for (i = 0; i < 6; i = i + 1) begin
      // Overload only counts while driven, the rest only while off
      flag_set[grp_base(i) + `SSDS_GRP_OVERLOAD] =
        drv[i] & ovl_s[i];
      flag_set[grp_base(i) + `SSDS_GRP_OPEN] =
        ~drv[i] & open_s[i];
      flag_set[grp_base(i) + `SSDS_GRP_SHORT] =
        ~drv[i] & sgnd_s[i];
    end
  end

  // ----------------------------------------------------------------
  // Error register and transfer state
  // ----------------------------------------------------------------
  reg [WBITS-1:0] flags_reg;
  reg [WBITS-1:0] shift_reg;
  reg first_reg;
  wire clr_flags;

  // Clear on the first clock of a transfer or diagnostic reset low
  assign clr_flags = (sclk_rise & ~cs_n_s & first_reg) | ~dres_n_s;

  // Sticky flags; a same-cycle detection survives the clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_reg <= `SSDS_FLAGS_RESET;
    end else if (clr_flags) begin
      flags_reg <= flag_set;
    end else begin
      flags_reg <= flags_reg | flag_set;
    end
  end

  assign fault_flags = flags_reg;

  // Snapshot on select, then shift toward the output bit by bit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_reg <= `SSDS_FLAGS_RESET;
      first_reg <= 1'b0;
    end else if (cs_fall) begin
      shift_reg <= flags_reg | flag_set;
      first_reg <= 1'b1;
    end else if (!cs_n_s && sclk_rise) begin
      shift_reg <= {sin_s, shift_reg[WBITS-1:1]};
      first_reg <= 1'b0;
    end else if (cs_n_s) begin
      first_reg <= 1'b0;
    end
  end

  // Data out shows the head bit; idles low when deselected
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      diag_serial_out <= 1'b0;
    end else if (cs_n_s) begin
      diag_serial_out <= 1'b0;
    end else begin
      diag_serial_out <= shift_reg[0];
    end
  end

endmodule

`default_nettype wire

// file: dv/ssds_switch_diag_monitor.sv
// Port-level checks of the sixfold switch diagnostic block
`default_nettype none
module ssds_switch_diag_monitor #(
  parameter int WBITS = 19
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrl_in_ch1,
  input wire logic ctrl_in_ch6,
  input wire logic ctrl_in_aux,
  input wire logic [5:0] sense_overload,
  input wire logic [5:0] sense_open_load,
  input wire logic [5:0] sense_short_gnd,
  input wire logic [5:0] sense_shorted_load,
  input wire logic sense_overtemp,
  input wire logic diag_reset_n,
  input wire logic diag_cs_n,
  input wire logic drain_ch1,
  input wire logic drain_ch6,
  input wire logic drain_aux,
  input wire logic diag_serial_out,
  input wire logic [WBITS-1:0] fault_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Three cycles of sync and register latency on every control path
  aux_follow_a: assert property (ctrl_in_aux[*4] |-> drain_aux)
    else $error("aux switch not on");
  ch_off_a: assert property ((!ctrl_in_ch1)[*4] |-> !drain_ch1)
    else $error("ch1 on without request");
  short_off_a: assert property (
    (sense_shorted_load[0] && drain_ch1) ##1 sense_shorted_load[0][*7]
    |-> ##1 !drain_ch1) else $error("short did not shut ch1");
  latch_hold_a: assert property (ctrl_in_ch1[*5] ##0 $fell(drain_ch1)
    ##1 ctrl_in_ch1[*6] |-> !drain_ch1) else $error("latch released");
  idle_out_a: assert property (diag_cs_n[*4] |-> !diag_serial_out)
    else $error("serial out busy while idle");
  thermal_set_a: assert property (sense_overtemp[*4] |-> fault_flags[0])
    else $error("thermal flag missing");
  open_set_a: assert property (
    (sense_open_load[0] && !ctrl_in_ch1 && !drain_ch1)[*4]
    |-> fault_flags[17]) else $error("ch1 open flag missing");
  ovl_set_a: assert property (
    (sense_overload[5] && ctrl_in_ch6 && drain_ch6)[*4]
    |-> fault_flags[1]) else $error("ch6 overload flag missing");
  reset_clr_a: assert property (
    (!diag_reset_n && ~|{sense_overload, sense_open_load, sense_short_gnd,
    sense_overtemp})[*4] |-> fault_flags == '0) else $error("flags kept");
  cover property ($fell(diag_cs_n));
  cover property (ctrl_in_ch1 && $fell(drain_ch1));
  cover property (sense_overtemp ##3 fault_flags[0]);
endmodule
`default_nettype wire

// file: dv/ssds_host_model.sv
// Controller reading the cascaded serial diagnostic chain
`default_nettype none
module ssds_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic slow,
  input wire logic sdo,
  output logic cs_n,
  output logic sclk,
  output logic done,
  output logic [19:0] word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    done = 1'b0;
    word = '0;
  end
  // Clock stands low outside frames; bit k is taken before the k-th rise
  always begin
    @(posedge clk iff go);
    @(negedge clk);
    done = 1'b0;
    cs_n = 1'b0;
    repeat (6) @(negedge clk);
    for (int k = 0; k < 20; k++) begin
      word[k] = sdo;
      sclk = 1'b1;
      repeat (slow ? 12 : 4) @(negedge clk);
      sclk = 1'b0;
      repeat (slow ? 12 : 4) @(negedge clk);
    end
    cs_n = 1'b1;
    // Leave select idle a few cycles so the next frame sees a clean fall
    repeat (4) @(negedge clk);
    done = 1'b1;
  end
endmodule
`default_nettype wire

// file: dv/ssds_switch_diag_tb.sv
// Self-checking bench of the sixfold switch diagnostic block
`default_nettype none
module ssds_switch_diag_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, otp = 1'b0, dr_n = 1'b1, si = 1'b0;
  logic go = 1'b0, slow = 1'b0;
  logic [6:0] ctl = '0;
  logic [5:0] ovl = '0, opn = '0, sgn = '0, shl = '0, m;
  logic cs_n, sclk, sdo, done;
  logic [6:0] drn;
  logic [19:0] word, r;
  logic [19:0] exp_q[$];
  logic [31:0] rs = 32'h0001_4b38;
  int miscompares = 0, n_tests = 0;
  always #25 clk = ~clk;
  ssds_switch_diag #(.SHORT_CYC(4)) i_ssds_switch_diag (
    .clk(clk), .rst(rst), .ctrl_in_ch1(ctl[0]), .ctrl_in_ch2(ctl[1]),
    .ctrl_in_ch3(ctl[2]), .ctrl_in_ch4(ctl[3]), .ctrl_in_ch5(ctl[4]),
    .ctrl_in_ch6(ctl[5]), .ctrl_in_aux(ctl[6]), .sense_overload(ovl),
    .sense_open_load(opn), .sense_short_gnd(sgn),
    .sense_shorted_load(shl), .sense_overtemp(otp), .diag_reset_n(dr_n),
    .diag_cs_n(cs_n), .diag_sclk(sclk), .diag_serial_in(si),
    .drain_ch1(drn[0]), .drain_ch2(drn[1]), .drain_ch3(drn[2]),
    .drain_ch4(drn[3]), .drain_ch5(drn[4]), .drain_ch6(drn[5]),
    .drain_aux(drn[6]), .diag_serial_out(sdo), .fault_flags());
  ssds_host_model i_ssds_host_model (.clk(clk), .go(go), .slow(slow),
    .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .done(done), .word(word));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Word: thermal first, then ch6 down to ch1, cascade bit last
  function automatic logic [19:0] wrd(logic t, logic [5:0] v, o, g,
    logic s);
    logic [19:0] w;
    w = {s, 18'h0_0000, t};
    for (int c = 0; c < 6; c++) begin
      w[1 + 3 * (5 - c)] = v[c];
      w[2 + 3 * (5 - c)] = o[c];
      w[3 + 3 * (5 - c)] = g[c];
    end
    return w;
  endfunction
  task automatic chk(string nm, logic [19:0] ex, logic [19:0] got);
    n_tests++;
    if (ex !== got) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Note the expected word, start a frame, wait a bounded time for it
  task automatic rd(logic [19:0] ex);
    int i;
    exp_q.push_back(ex);
    si = ex[19];
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(2);
    for (i = 0; i < 12000 && !done; i++) @(negedge clk);
    if (!done) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  // Oldest note is matched against each finished frame
  always @(posedge done) chk("word", exp_q.pop_front(), word);
  initial begin
    cyc(8);
    rst = 1'b0;
    ctl = 7'(rnd());
    cyc(5);
    chk("drains", 20'(ctl), 20'(drn));
    $display("t1 done");
    ctl = '0;
    dr_n = 1'b0;
    cyc(3);
    dr_n = 1'b1;
    r = 20'(rnd());
    m = 6'(rnd());
    {opn, sgn, otp} = {m, ~m & r[5:0], r[6]};
    cyc(4);
    {opn, sgn, otp} = '0;
    cyc(6);
    rd(wrd(r[6], 0, m, ~m & r[5:0], r[7]));
    slow = 1'b1;
    rd(wrd(0, 0, 0, 0, r[8]));
    slow = 1'b0;
    $display("t2 done");
    ctl = 7'h3f;
    cyc(4);
    {ovl, otp} = {m, 1'b1};
    cyc(5);
    chk("drains hot", 20'h0_003f, 20'(drn));
    {ovl, otp} = '0;
    cyc(2);
    rd(wrd(1, m, 0, 0, r[9]));
    $display("t3 done");
    shl = 6'h01;
    cyc(12);
    shl = '0;
    chk("ch1 short", 0, 20'(drn[0]));
    cyc(8);
    chk("ch1 held", 0, 20'(drn[0]));
    ctl[0] = 1'b0;
    cyc(4);
    ctl[0] = 1'b1;
    cyc(5);
    chk("ch1 back", 1, 20'(drn[0]));
    $display("t4 done");
    otp = 1'b1;
    cyc(4);
    otp = 1'b0;
    dr_n = 1'b0;
    cyc(4);
    dr_n = 1'b1;
    rd(wrd(0, 0, 0, 0, r[10]));
    $display("t5 done");
    cyc(4);
    report_and_stop();
  end
endmodule
bind ssds_switch_diag ssds_switch_diag_monitor #(.WBITS(WBITS))
  i_ssds_switch_diag_monitor (.*);
`default_nettype wire
